//--- hw/apf_fault_logic.v
// protection and fault handling for a four half-bridge class-D stage
// assumes all sensor flags are synchronous to clk; frameStart marks PWM frames
`include "apf_defs.vh"
module apf_fault_logic #(
    parameter OVL_MAX = `APF_OVL_MAX,
    parameter RAMP_CYC = `APF_RAMP_CYC
) (
    input wire clk,
    input wire reset,
    input wire resetInN,
    input wire frameStart,
    input wire [3:0] pwmIn,
    input wire [3:0] trimCode,
    input wire [3:0] overcurrent,
    input wire [1:0] imbalance,
    input wire singleEndedMode,
    input wire parallelBridgedMode,
    input wire supplyStartup,
    input wire shortToGround,
    input wire shortToSupply,
    input wire clipping,
    input wire thermalWarning,
    input wire thermalShutdown,
    input wire undervoltageGuard,
    output reg [3:0] gateOut,
    output reg [3:0] bridgeEnable,
    output wire latchedMode,
    output wire [1:0] tripLevel,
    output wire faultOut,
    output wire faultOe,
    output wire clipHeatWarnOut,
    output wire clipHeatWarnOe,
    output wire checkBusy
);
    // -----------------------------------------------------------------
    // resistor decode
    // -----------------------------------------------------------------
    function [2:0] decodeTrim;
        input [3:0] code;
        begin
            if (code <= `APF_TRIM_CB_HI)
                decodeTrim = {1'b0, code[1:0]};
            else if (code <= `APF_TRIM_LT_HI)
                decodeTrim = {1'b1, code[1:0]};
            else
                decodeTrim = {1'b0, `APF_LEVEL_LOWEST};
        end
    endfunction

    wire [2:0] trimDec = decodeTrim(trimCode);
    assign latchedMode = trimDec[2];
    assign tripLevel = trimDec[1:0];

    // -----------------------------------------------------------------
    // pin-short check state machine
    // -----------------------------------------------------------------
    localparam PS_IDLE = 2'h0;
    localparam PS_GND = 2'h1;
    localparam PS_SUP = 2'h2;
    localparam PS_DONE = 2'h3;
    reg [1:0] psState_r;
    reg [1:0] psState_nxt;

    always @* begin
        psState_nxt = psState_r;
        case (psState_r)
            PS_IDLE: begin
                // only supply start-up launches it, never the reset pin
                if (supplyStartup)
                    psState_nxt = singleEndedMode ? PS_DONE : PS_GND;
            end
            PS_GND: begin
                if (!shortToGround)
                    psState_nxt = PS_SUP;
            end
            PS_SUP: begin
                if (shortToGround)
                    psState_nxt = PS_GND;
                else if (!shortToSupply)
                    psState_nxt = PS_DONE;
            end
            PS_DONE: psState_nxt = PS_DONE;
            default: psState_nxt = PS_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (reset)
            psState_r <= PS_IDLE;
        else
            psState_r <= psState_nxt;
    end

    wire checking = (psState_r == PS_GND) || (psState_r == PS_SUP);
    wire started = (psState_r == PS_DONE);
    assign checkBusy = checking;

    // -----------------------------------------------------------------
    // reset pin edge, global latch, ramp-down
    // -----------------------------------------------------------------
    reg resetInPrev_r;
    reg thermalLatch_r;
    reg [7:0] rampCnt_r;
    wire resetHeld = !resetInN && !checking;
    wire resetRise = resetInN && !resetInPrev_r && !checking;

    always @(posedge clk) begin
        if (reset) begin
            resetInPrev_r <= 1'b1;
            thermalLatch_r <= 1'b0;
            rampCnt_r <= 8'h00;
        end else begin
            if (!checking)
                resetInPrev_r <= resetInN;
            if (thermalShutdown)
                thermalLatch_r <= 1'b1;
            else if (resetRise)
                thermalLatch_r <= 1'b0;
            if (!resetHeld)
                rampCnt_r <= 8'h00;
            else if (rampCnt_r != RAMP_CYC[7:0])
                rampCnt_r <= rampCnt_r + 8'h01;
        end
    end

    wire rampDone = resetHeld && (rampCnt_r == RAMP_CYC[7:0]);
    wire globalOff = thermalLatch_r || undervoltageGuard || !started || checking || rampDone;

    // -----------------------------------------------------------------
    // half bridges and channel grouping
    // -----------------------------------------------------------------
    wire [3:0] flip;
    wire [3:0] tripped;
    wire dcOn = !singleEndedMode;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : hb
            apf_half_bridge #(
                .OVL_MAX(OVL_MAX),
                .CW(8)
            ) u_hb (
                .clk(clk),
                .reset(reset),
                .frameStart(frameStart),
                .overcurrent(overcurrent[g] && started),
                .imbalance(imbalance[g/2] && started),
                .latchedMode(latchedMode),
                .dcCheckOn(dcOn),
                .clearTrip(resetRise),
                .flip_r(flip[g]),
                .tripped_r(tripped[g]),
                .count_r()
            );
        end
    endgenerate

    // a trip takes its full bridge, or all four in parallel-bridged mode
    wire [1:0] chanTrip = {tripped[3] | tripped[2], tripped[1] | tripped[0]};
    wire allTrip = parallelBridgedMode && (|chanTrip);
    wire [3:0] chanOff = {{2{chanTrip[1] | allTrip}}, {2{chanTrip[0] | allTrip}}};

    // -----------------------------------------------------------------
    // pulse injector: every fourth frame while saturated
    // -----------------------------------------------------------------
    reg [1:0] frameCnt_r;
    reg injecting_r;
    wire saturated = clipping || (|flip);

    always @(posedge clk) begin
        if (reset) begin
            frameCnt_r <= 2'h0;
            injecting_r <= 1'b0;
        end else if (frameStart) begin
            frameCnt_r <= frameCnt_r + 2'h1;
            injecting_r <= saturated && (frameCnt_r == 2'h3);
        end else begin
            injecting_r <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            gateOut <= 4'h0;
            bridgeEnable <= 4'h0;
        end else begin
            bridgeEnable <= ~({4{globalOff}} | chanOff);
            gateOut <= ((pwmIn ^ flip) | {4{injecting_r}}) & ~({4{globalOff}} | chanOff);
        end
    end

    // -----------------------------------------------------------------
    // clip pulse stretch and open-drain indications
    // -----------------------------------------------------------------
    reg [3:0] clipCnt_r;
    localparam [31:0] CLIP_LOAD = `APF_CLIP_PULSE_CYC;
    always @(posedge clk) begin
        if (reset)
            clipCnt_r <= 4'h0;
        else if (clipping)
            clipCnt_r <= CLIP_LOAD[3:0];
        else if (clipCnt_r != 4'h0)
            clipCnt_r <= clipCnt_r - 4'h1;
    end

    reg faultLow_r;
    reg warnLow_r;
    always @(posedge clk) begin
        if (reset) begin
            faultLow_r <= 1'b0;
            warnLow_r <= 1'b0;
        end else begin
            faultLow_r <= checking || (!resetHeld && (globalOff || (|tripped)));
            warnLow_r <= thermalWarning || (clipCnt_r != 4'h0);
        end
    end

    // open drain: drive low only
    assign faultOut = 1'b0;
    assign faultOe = faultLow_r;
    assign clipHeatWarnOut = 1'b0;
    assign clipHeatWarnOe = warnLow_r;
endmodule

//--- hw/apf_defs.vh
// constants for the amplifier protection and fault logic
// assumes a 10 MHz clock and sensor flags already synchronised to it
// Functional notes
// - trim resistor code picks mode and trip level
// - out-of-range resistor gives lowest trip level
// - limiting flips half bridge until next frame
// - overload count up per overcurrent cycle, down per clean frame
// - count at maximum latches channel high impedance
// - latched mode trips on first overcurrent
// - clipping or limiting injects pulse every fourth frame
// - clip pulses drive warning output, self clearing
// - bridged imbalance drives count to maximum, shutdown
// - pin-short check only at supply start-up
// - two step check, hold high impedance on short
// - fault low, reset ignored during pin-short check
// - pin-short check skipped in single-ended mode
// - thermal warning drives warning output low
// - thermal shutdown latches global high impedance, fault
// - undervoltage forces high impedance and fault, self clearing
// - global fault latched until reset toggled
// - channel fault stops only its channel, all four in parallel-bridged mode
// - reset low forces fault output inactive
// - fault and warning are active-low open drain
// - reset low ramps down then high impedance
`ifndef APF_DEFS_VH
`define APF_DEFS_VH

// -----------------------------------------------------------------
// trip-set resistor codes (4 bits: 0..3 limiting, 4..7 latched)
// -----------------------------------------------------------------
`define APF_TRIM_W 4
`define APF_TRIM_CB_LO 4'h0
`define APF_TRIM_CB_HI 4'h3
`define APF_TRIM_LT_LO 4'h4
`define APF_TRIM_LT_HI 4'h7
`define APF_LEVEL_LOWEST 2'h3

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define APF_CLK_HZ 10000000
`define APF_CLIP_PULSE_NS 500
`define APF_CLIP_PULSE_CYC ((`APF_CLIP_PULSE_NS * (`APF_CLK_HZ / 1000000) + 999) / 1000)
`define APF_RAMP_CYC 16
`define APF_OVL_MAX 15
`define APF_INJECT_PERIOD 4

`endif

//--- hw/apf_half_bridge.v
// one half bridge: current limiting flip, overload counter and latch
// assumes frameStart is a one-cycle pulse at each PWM frame begin
module apf_half_bridge #(
    parameter OVL_MAX = 15,
    parameter CW = 8
) (
    input wire clk,
    input wire reset,
    input wire frameStart,
    input wire overcurrent,
    input wire imbalance,
    input wire latchedMode,
    input wire dcCheckOn,
    input wire clearTrip,
    output reg flip_r,
    output reg tripped_r,
    output reg [CW-1:0] count_r
);
    reg ocSeen_r;
    reg [CW-1:0] count_nxt;
    wire [CW-1:0] maxVal = OVL_MAX[CW-1:0];

    always @* begin
        count_nxt = count_r;
        if (overcurrent && !latchedMode && count_r != maxVal)
            count_nxt = count_r + {{(CW-1){1'b0}}, 1'b1};
        else if (imbalance && dcCheckOn && count_r != maxVal)
            count_nxt = count_r + {{(CW-1){1'b0}}, 1'b1};
        else if (frameStart && !ocSeen_r && count_r != {CW{1'b0}})
            count_nxt = count_r - {{(CW-1){1'b0}}, 1'b1};
    end

    always @(posedge clk) begin
        if (reset) begin
            flip_r <= 1'b0;
            tripped_r <= 1'b0;
            count_r <= {CW{1'b0}};
            ocSeen_r <= 1'b0;
        end else begin
            // flip cancelled at frame begin unless a new event lands then
            if (overcurrent && !latchedMode)
                flip_r <= 1'b1;
            else if (frameStart)
                flip_r <= 1'b0;
            if (overcurrent)
                ocSeen_r <= 1'b1;
            else if (frameStart)
                ocSeen_r <= 1'b0;
            if (clearTrip) begin
                count_r <= {CW{1'b0}};
                // a latched-mode trip landing on the release edge must not be lost
                tripped_r <= overcurrent && latchedMode;
            end else begin
                count_r <= count_nxt;
                if ((overcurrent && latchedMode) || count_nxt == maxVal)
                    tripped_r <= 1'b1;
            end
        end
    end
endmodule

//--- verif/apf_mcu_model.sv
// controller model that owns the device reset pin
// restartReq is a one-cycle request from the bench
module apf_mcu_model #(
    parameter int HOLD_CYC = 40
) (
    input wire logic clk,
    input wire logic clipHeatWarnOe,
    input wire logic restartReq,
    output logic resetInN
);
    timeunit 1ns;
    timeprecision 1ns;
    initial resetInN = 1'h1;
    always @(posedge clk) begin
        if (restartReq) begin
            resetInN <= 1'h0;
            // scaled cool-off; the full figure would dominate run time
            repeat (HOLD_CYC) @(posedge clk);
            while (clipHeatWarnOe) @(posedge clk);
            resetInN <= 1'h1;
        end
    end
endmodule

//--- verif/apf_fault_props.sv
// assertions on the top ports of the fault logic
// one clock domain, synchronous active-high reset
module apf_fault_props (
    input logic clk,
    input logic reset,
    input logic resetInN,
    input logic [3:0] trimCode,
    input logic [3:0] overcurrent,
    input logic clipping,
    input logic thermalWarning,
    input logic thermalShutdown,
    input logic undervoltageGuard,
    input logic [3:0] bridgeEnable,
    input logic latchedMode,
    input logic [1:0] tripLevel,
    input logic faultOe,
    input logic clipHeatWarnOe,
    input logic checkBusy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence sLatchedHit;
        latchedMode && overcurrent[0] && resetInN && !checkBusy ##1 resetInN;
    endsequence
    sequence sHotHit;
        thermalShutdown && resetInN ##1 resetInN;
    endsequence
    a_low_level: assert property (trimCode[3] |-> tripLevel == 2'h3) else $error("level");
    a_latch_trip: assert property (sLatchedHit |=> bridgeEnable[1:0] == 2'h0) else $error("latched");
    a_hot_latch: assert property (sHotHit |=> faultOe && bridgeEnable == 4'h0) else $error("hot");
    a_uv_hiz: assert property (undervoltageGuard && resetInN |=> faultOe && bridgeEnable == 4'h0) else $error("uv");
    a_reset_quiet: assert property (!resetInN && !checkBusy |=> !faultOe) else $error("quiet");
    a_heat_warn: assert property (thermalWarning |=> clipHeatWarnOe) else $error("warn");
    a_clip_warn: assert property (clipping |-> ##2 clipHeatWarnOe [*5]) else $error("clip");
    a_check_fault: assert property (checkBusy ##1 checkBusy |-> faultOe) else $error("check");
endmodule

bind apf_fault_logic apf_fault_props u_props (.clk(clk), .reset(reset), .resetInN(resetInN),
    .trimCode(trimCode), .overcurrent(overcurrent), .clipping(clipping), .thermalWarning(thermalWarning),
    .thermalShutdown(thermalShutdown), .undervoltageGuard(undervoltageGuard), .bridgeEnable(bridgeEnable),
    .latchedMode(latchedMode), .tripLevel(tripLevel), .faultOe(faultOe), .clipHeatWarnOe(clipHeatWarnOe),
    .checkBusy(checkBusy));

//--- verif/apf_fault_logic_tb.sv
// bench for the fault logic: decode rows, then hand-written fault cases
// counts reduced by parameter; the controller model owns resetInN
module apf_fault_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, reset = 1'h1, frameStart = 1'h0, supplyStartup = 1'h0, shortToGround = 1'h0;
    logic shortToSupply = 1'h0, singleEndedMode = 1'h0, clipping = 1'h0, thermalWarning = 1'h0;
    logic thermalShutdown = 1'h0, undervoltageGuard = 1'h0, restartReq = 1'h0, parallelBridgedMode = 1'h0;
    logic resetInN, latchedMode, faultOe, clipHeatWarnOe, checkBusy, faultOut, clipHeatWarnOut;
    logic [3:0] trimCode = 4'h0, overcurrent = 4'h0, pwmIn = 4'h5, gateOut, bridgeEnable;
    logic [1:0] imbalance = 2'h0, tripLevel;
    logic [2:0] frameCnt = 3'h0;
    int miscompares = 0, checksDone = 0, pulses = 0;
    // trimCode, latchedMode, tripLevel
    logic [6:0] rows [10] = '{7'h00, 7'h09, 7'h12, 7'h1b, 7'h24, 7'h2d, 7'h36, 7'h3f, 7'h43, 7'h7b};
    apf_fault_logic #(.OVL_MAX(3), .RAMP_CYC(2)) u_dut (.clk(clk), .reset(reset), .resetInN(resetInN),
        .frameStart(frameStart), .pwmIn(pwmIn), .trimCode(trimCode), .overcurrent(overcurrent),
        .imbalance(imbalance), .singleEndedMode(singleEndedMode), .parallelBridgedMode(parallelBridgedMode),
        .supplyStartup(supplyStartup), .shortToGround(shortToGround), .shortToSupply(shortToSupply),
        .clipping(clipping), .thermalWarning(thermalWarning), .thermalShutdown(thermalShutdown),
        .undervoltageGuard(undervoltageGuard), .gateOut(gateOut), .bridgeEnable(bridgeEnable),
        .latchedMode(latchedMode), .tripLevel(tripLevel), .faultOut(faultOut), .faultOe(faultOe),
        .clipHeatWarnOut(clipHeatWarnOut), .clipHeatWarnOe(clipHeatWarnOe), .checkBusy(checkBusy));
    apf_mcu_model u_mcu (.clk(clk), .clipHeatWarnOe(clipHeatWarnOe), .restartReq(restartReq), .resetInN(resetInN));
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        frameCnt <= frameCnt + 3'h1;
        frameStart <= frameCnt == 3'h7;
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_be(input logic [3:0] exp, input string what);
        for (int n = 0; n < 200 && bridgeEnable !== exp; n++) settle(1);
        chk(bridgeEnable, exp, what);
    endtask
    task automatic pulse_oc(input int n);
        @(posedge clk) overcurrent <= 4'h1;
        repeat (n) @(posedge clk);
        overcurrent <= 4'h0;
    endtask
    task automatic recover;
        @(posedge clk) restartReq <= 1'h1;
        @(posedge clk) restartReq <= 1'h0;
        wait_be(4'h0, "ramp down");
        wait_be(4'hf, "resumed");
        chk({3'h0, checkBusy}, 4'h0, "no recheck");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        foreach (rows[i]) begin
            @(posedge clk) trimCode <= rows[i][6:3];
            #1;
            if (!rows[i][6]) chk({3'h0, latchedMode}, {3'h0, rows[i][2]}, "mode");
            chk({2'h0, tripLevel}, {2'h0, rows[i][1:0]}, "level");
        end
        $display("test decode done");
        @(posedge clk) trimCode <= 4'h0;
        supplyStartup <= 1'h1;
        shortToGround <= 1'h1;
        @(posedge clk) supplyStartup <= 1'h0;
        restartReq <= 1'h1;
        @(posedge clk) restartReq <= 1'h0;
        settle(60);
        chk({checkBusy, faultOe, bridgeEnable[1:0]}, 4'hc, "ground step");
        @(posedge clk) shortToGround <= 1'h0;
        shortToSupply <= 1'h1;
        settle(20);
        chk({checkBusy, faultOe, bridgeEnable[1:0]}, 4'hc, "supply step");
        @(posedge clk) shortToSupply <= 1'h0;
        wait_be(4'hf, "start-up");
        chk({3'h0, faultOe}, 4'h0, "fault freed");
        chk(gateOut, 4'h5, "pwm follow");
        chk({2'h0, faultOut, clipHeatWarnOut}, 4'h0, "open drain");
        $display("test pin-short done");
        do @(posedge clk); while (frameStart !== 1'h1);
        pulse_oc(1);
        settle(2);
        chk(gateOut, 4'h4, "flip");
        settle(8);
        chk(gateOut, 4'h5, "flip cancelled");
        settle(32);
        do @(posedge clk); while (frameStart !== 1'h1);
        pulse_oc(2);
        settle(2);
        chk(bridgeEnable, 4'hf, "count decays");
        pulse_oc(1);
        wait_be(4'hc, "overload");
        recover();
        @(posedge clk) trimCode <= 4'h4;
        pulse_oc(1);
        wait_be(4'hc, "latched");
        recover();
        @(posedge clk) parallelBridgedMode <= 1'h1;
        pulse_oc(1);
        wait_be(4'h0, "parallel trip");
        @(posedge clk) parallelBridgedMode <= 1'h0;
        recover();
        @(posedge clk) imbalance <= 2'h2;
        wait_be(4'h3, "dc trip");
        @(posedge clk) imbalance <= 2'h0;
        recover();
        $display("test overcurrent done");
        @(posedge clk) thermalWarning <= 1'h1;
        thermalShutdown <= 1'h1;
        @(posedge clk) thermalShutdown <= 1'h0;
        settle(5);
        chk({faultOe, clipHeatWarnOe, bridgeEnable[1:0]}, 4'hc, "hot");
        @(posedge clk) restartReq <= 1'h1;
        @(posedge clk) restartReq <= 1'h0;
        settle(60);
        chk({faultOe, resetInN, bridgeEnable[1:0]}, 4'h0, "held cool");
        @(posedge clk) thermalWarning <= 1'h0;
        wait_be(4'hf, "hot restart");
        @(posedge clk) undervoltageGuard <= 1'h1;
        settle(2);
        chk({faultOe, bridgeEnable[2:0]}, 4'h8, "uv");
        @(posedge clk) undervoltageGuard <= 1'h0;
        wait_be(4'hf, "uv clear");
        @(posedge clk) clipping <= 1'h1;
        @(posedge clk) clipping <= 1'h0;
        settle(1);
        chk({3'h0, clipHeatWarnOe}, 4'h1, "clip");
        settle(10);
        chk({3'h0, clipHeatWarnOe}, 4'h0, "clip clear");
        // four frames of clipping hold exactly one injected pulse
        @(posedge clk) clipping <= 1'h1;
        do @(posedge clk); while (frameStart !== 1'h1);
        repeat (32) begin
            settle(1);
            if (gateOut === 4'hf) pulses++;
        end
        chk(pulses[3:0], 4'h1, "inject");
        @(posedge clk) clipping <= 1'h0;
        $display("test thermal supply clip done");
        @(posedge clk) reset <= 1'h1;
        singleEndedMode <= 1'h1;
        shortToGround <= 1'h1;
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk) supplyStartup <= 1'h1;
        @(posedge clk) supplyStartup <= 1'h0;
        imbalance <= 2'h3;
        settle(10);
        chk(bridgeEnable, 4'hf, "single-ended");
        $display("test single-ended done");
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule
